//--- core/pin_mux_pkg.sv
package pin_mux_pkg;

  localparam int B_W    = 8;
  localparam int C_W    = 6;
  localparam int ADDR_W = 8;

  // Byte addresses of the register words.
  localparam logic [7:0] ADDR_FSEL_B = 8'h00;
  localparam logic [7:0] ADDR_FSEL_C = 8'h04;
  localparam logic [7:0] ADDR_OUT_B  = 8'h08;
  localparam logic [7:0] ADDR_DIR_B  = 8'h0C;
  localparam logic [7:0] ADDR_OUT_C  = 8'h10;
  localparam logic [7:0] ADDR_DIR_C  = 8'h14;
  localparam logic [7:0] ADDR_PIN_B  = 8'h18;
  localparam logic [7:0] ADDR_PIN_C  = 8'h1C;
  localparam logic [7:0] ADDR_MODE   = 8'h20;

  // Bit positions inside the mode register, then its width.
  localparam int MODE_T0_CNT = 0;
  localparam int MODE_T1_CNT = 1;
  localparam int MODE_T2_CNT = 2;
  localparam int MODE_IRQ0_T = 3;
  localparam int MODE_IRQ1_T = 4;
  localparam int MODE_W      = 5;

  // Pins whose alternate role drives the pad.
  localparam logic [B_W-1:0] B_OUT_ROLE = 8'h88;
  localparam logic [C_W-1:0] C_OUT_ROLE = 6'h02;

  localparam logic [B_W-1:0]    FSEL_B_RST = 8'h00;
  localparam logic [C_W-1:0]    FSEL_C_RST = 6'h00;
  localparam logic [B_W-1:0]    PORT_B_RST = 8'h00;
  localparam logic [C_W-1:0]    PORT_C_RST = 6'h00;
  localparam logic [MODE_W-1:0] MODE_RST   = 5'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [B_W-1:0]    fsel_b;
    logic [C_W-1:0]    fsel_c;
    logic [B_W-1:0]    out_b;
    logic [B_W-1:0]    dir_b;
    logic [C_W-1:0]    out_c;
    logic [C_W-1:0]    dir_c;
    logic [MODE_W-1:0] mode;
  } regs_t;

  typedef struct packed {
    logic shift_clock;
    logic tx_data;
    logic sync_mode;
  } serial_tx_t;

endpackage

//--- core/port_b_c_alt_function_mux.sv
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
// How it works
// - B0 select 0: GPIO; 1: timer 2 count input, used in counter mode.
// - B1 select 0: GPIO; 1: timer 2 active-high capture/reload input.
// - B2 select 1: serial port 1 receive input; 0: GPIO.
// - B3 select 1: serial 1 shift clock if sync, else transmit data.
// - B4 select 1: interrupt 4 on rising edge; 0: GPIO.
// - B5 select 1: interrupt 5 on falling edge, active low; 0: GPIO.
// - B6 select 1: interrupt 6 on rising edge; 0: GPIO.
// - B7 select 1: drives one-cycle timer 2 overflow pulse; 0: GPIO.
// - C0 select 1: serial port 0 receive input; 0: GPIO.
// - C1 select 1: serial 0 shift clock if sync, else transmit data.
// - C2 select 1: interrupt 0 low, edge if type 1, level if 0.
// - C3 select 1: interrupt 1 low, edge if type 1, level if 0.
// - C4 select 1: timer 0 count input, used in counter mode only.
// - C5 select 1: timer 1 count input, used in counter mode only.
module port_b_c_alt_function_mux (
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  input  wire logic                          ce,
  input  wire logic [pin_mux_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [31:0]                   wdata,
  input  wire logic [3:0]                    wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  input  wire logic [pin_mux_pkg::ADDR_W-1:0] araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [31:0]                        rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  input  wire logic [pin_mux_pkg::B_W-1:0]   pin_b_in,
  output logic [pin_mux_pkg::B_W-1:0]        pin_b_out,
  output logic [pin_mux_pkg::B_W-1:0]        pin_b_oe_n,
  input  wire logic [pin_mux_pkg::C_W-1:0]   pin_c_in,
  output logic [pin_mux_pkg::C_W-1:0]        pin_c_out,
  output logic [pin_mux_pkg::C_W-1:0]        pin_c_oe_n,
  input  wire pin_mux_pkg::serial_tx_t       serial0_tx,
  input  wire pin_mux_pkg::serial_tx_t       serial1_tx,
  input  wire logic                          timer2_overflow_pulse,
  output logic                               timer2_count_input,
  output logic                               timer2_capture_reload_input,
  output logic                               serial1_receive_input,
  output logic                               ext_irq_four,
  output logic                               ext_irq_five_low,
  output logic                               ext_irq_six,
  output logic                               serial0_receive_input,
  output logic                               ext_irq_zero_low,
  output logic                               ext_irq_one_low,
  output logic                               timer_zero_count_input,
  output logic                               timer_one_count_input
);

  // Writable words; the pin words are read-only.
  function automatic logic is_writable(input logic [7:0] a);
    case (a)
      pin_mux_pkg::ADDR_FSEL_B,
      pin_mux_pkg::ADDR_FSEL_C,
      pin_mux_pkg::ADDR_OUT_B,
      pin_mux_pkg::ADDR_DIR_B,
      pin_mux_pkg::ADDR_OUT_C,
      pin_mux_pkg::ADDR_DIR_C,
      pin_mux_pkg::ADDR_MODE:  is_writable = 1'b1;
      default:                 is_writable = 1'b0;
    endcase
  endfunction

  function automatic logic is_readable(input logic [7:0] a);
    is_readable = is_writable(a) || a == pin_mux_pkg::ADDR_PIN_B
                  || a == pin_mux_pkg::ADDR_PIN_C;
  endfunction

  // An edge seen on a selected pin, rising when rise is set.
  function automatic logic pin_edge(input logic sel, input logic now,
                                    input logic prev, input logic rise);
    pin_edge = sel && (rise ? (now && !prev) : (!now && prev));
  endfunction

  pin_mux_pkg::regs_t regs;
  pin_mux_pkg::regs_t next_regs;

  logic                     aw_held;
  logic                     next_aw_held;
  logic [7:0]               aw_addr;
  logic [7:0]               next_aw_addr;
  logic                     w_held;
  logic                     next_w_held;
  logic [7:0]               w_data;
  logic [7:0]               next_w_data;
  logic                     w_lane0;
  logic                     next_w_lane0;
  logic                     do_write;
  logic                     next_awready;
  logic                     next_wready;
  logic                     next_bvalid;
  logic [1:0]               next_bresp;
  logic                     next_arready;
  logic                     next_rvalid;
  logic [31:0]              next_rdata;
  logic [1:0]               next_rresp;

  logic [pin_mux_pkg::B_W-1:0] prev_b;
  logic [pin_mux_pkg::C_W-1:0] prev_c;
  logic [pin_mux_pkg::B_W-1:0] func_b;
  logic [pin_mux_pkg::C_W-1:0] func_c;
  logic [pin_mux_pkg::B_W-1:0] next_b_out;
  logic [pin_mux_pkg::B_W-1:0] next_b_oe_n;
  logic [pin_mux_pkg::C_W-1:0] next_c_out;
  logic [pin_mux_pkg::C_W-1:0] next_c_oe_n;
  logic [10:0]                 periph;
  logic [10:0]                 next_periph;
  logic                        tx1;
  logic                        tx0;

  // Bus slave: address and data are taken in either order, then written.
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_lane0 = w_lane0;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    do_write     = aw_held && w_held && !bvalid;
    if (awvalid && awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_held  = 1'b1;
      next_w_data  = wdata[7:0];
      next_w_lane0 = wstrb[0];
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_bvalid  = 1'b1;
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bresp   = is_writable(aw_addr) ? pin_mux_pkg::RESP_OKAY
                                          : pin_mux_pkg::RESP_SLVERR;
    end
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_rresp  = is_readable(araddr) ? pin_mux_pkg::RESP_OKAY
                                        : pin_mux_pkg::RESP_SLVERR;
      case (araddr)
        pin_mux_pkg::ADDR_FSEL_B: next_rdata = {24'h0, regs.fsel_b};
        pin_mux_pkg::ADDR_FSEL_C: next_rdata = {26'h0, regs.fsel_c};
        pin_mux_pkg::ADDR_OUT_B:  next_rdata = {24'h0, regs.out_b};
        pin_mux_pkg::ADDR_DIR_B:  next_rdata = {24'h0, regs.dir_b};
        pin_mux_pkg::ADDR_OUT_C:  next_rdata = {26'h0, regs.out_c};
        pin_mux_pkg::ADDR_DIR_C:  next_rdata = {26'h0, regs.dir_c};
        pin_mux_pkg::ADDR_PIN_B:  next_rdata = {24'h0, prev_b};
        pin_mux_pkg::ADDR_PIN_C:  next_rdata = {26'h0, prev_c};
        pin_mux_pkg::ADDR_MODE:   next_rdata = {27'h0, regs.mode};
        default:                  next_rdata = 32'h0;
      endcase
    end
    // Ready is dropped while a word is held, which back-pressures the master.
    next_awready = !next_aw_held;
    next_wready  = !next_w_held;
    next_arready = !next_rvalid;
  end

  always_comb begin
    next_regs = regs;
    if (do_write && w_lane0) begin
      case (aw_addr)
        pin_mux_pkg::ADDR_FSEL_B: next_regs.fsel_b = w_data;
        pin_mux_pkg::ADDR_FSEL_C: next_regs.fsel_c = w_data[5:0];
        pin_mux_pkg::ADDR_OUT_B:  next_regs.out_b  = w_data;
        pin_mux_pkg::ADDR_DIR_B:  next_regs.dir_b  = w_data;
        pin_mux_pkg::ADDR_OUT_C:  next_regs.out_c  = w_data[5:0];
        pin_mux_pkg::ADDR_DIR_C:  next_regs.dir_c  = w_data[5:0];
        pin_mux_pkg::ADDR_MODE:   next_regs.mode   = w_data[4:0];
        default:                  next_regs        = regs;
      endcase
    end
  end

  // Transmit pins carry the shift clock in sync mode, data otherwise.
  assign tx1 = serial1_tx.sync_mode ? serial1_tx.shift_clock
                                    : serial1_tx.tx_data;
  assign tx0 = serial0_tx.sync_mode ? serial0_tx.shift_clock
                                    : serial0_tx.tx_data;
  assign func_b = {timer2_overflow_pulse, 3'h0, tx1, 3'h0};
  assign func_c = {4'h0, tx0, 1'h0};

  // An input role releases the pad; an output role drives it.
  genvar gi;
  generate
    for (gi = 0; gi < pin_mux_pkg::B_W; gi++) begin : g_pin_b
      assign next_b_out[gi]  = regs.fsel_b[gi] ? func_b[gi]
                                               : regs.out_b[gi];
      assign next_b_oe_n[gi] = regs.fsel_b[gi]
                               ? !pin_mux_pkg::B_OUT_ROLE[gi]
                               : !regs.dir_b[gi];
    end
    for (gi = 0; gi < pin_mux_pkg::C_W; gi++) begin : g_pin_c
      assign next_c_out[gi]  = regs.fsel_c[gi] ? func_c[gi]
                                               : regs.out_c[gi];
      assign next_c_oe_n[gi] = regs.fsel_c[gi]
                               ? !pin_mux_pkg::C_OUT_ROLE[gi]
                               : !regs.dir_c[gi];
    end
  endgenerate

  // Deselected inputs present their idle level to the peripheral.
  always_comb begin
    next_periph[0] = regs.fsel_b[0] && pin_b_in[0]
                     && regs.mode[pin_mux_pkg::MODE_T2_CNT];
    next_periph[1] = regs.fsel_b[1] && pin_b_in[1];
    next_periph[2] = regs.fsel_b[2] ? pin_b_in[2] : 1'b1;
    next_periph[3] = pin_edge(regs.fsel_b[4], pin_b_in[4],
                              prev_b[4], 1'b1);
    next_periph[4] = !pin_edge(regs.fsel_b[5], pin_b_in[5],
                               prev_b[5], 1'b0);
    next_periph[5] = pin_edge(regs.fsel_b[6], pin_b_in[6],
                              prev_b[6], 1'b1);
    next_periph[6] = regs.fsel_c[0] ? pin_c_in[0] : 1'b1;
    next_periph[7] = !(regs.mode[pin_mux_pkg::MODE_IRQ0_T]
                       ? pin_edge(regs.fsel_c[2], pin_c_in[2],
                                  prev_c[2], 1'b0)
                       : regs.fsel_c[2] && !pin_c_in[2]);
    next_periph[8] = !(regs.mode[pin_mux_pkg::MODE_IRQ1_T]
                       ? pin_edge(regs.fsel_c[3], pin_c_in[3],
                                  prev_c[3], 1'b0)
                       : regs.fsel_c[3] && !pin_c_in[3]);
    next_periph[9] = regs.fsel_c[4] && pin_c_in[4]
                     && regs.mode[pin_mux_pkg::MODE_T0_CNT];
    next_periph[10] = regs.fsel_c[5] && pin_c_in[5]
                      && regs.mode[pin_mux_pkg::MODE_T1_CNT];
  end

  assign timer2_count_input          = periph[0];
  assign timer2_capture_reload_input = periph[1];
  assign serial1_receive_input       = periph[2];
  assign ext_irq_four                = periph[3];
  assign ext_irq_five_low            = periph[4];
  assign ext_irq_six                 = periph[5];
  assign serial0_receive_input       = periph[6];
  assign ext_irq_zero_low            = periph[7];
  assign ext_irq_one_low             = periph[8];
  assign timer_zero_count_input      = periph[9];
  assign timer_one_count_input       = periph[10];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regs.fsel_b <= pin_mux_pkg::FSEL_B_RST;
      regs.fsel_c <= pin_mux_pkg::FSEL_C_RST;
      regs.out_b  <= pin_mux_pkg::PORT_B_RST;
      regs.dir_b  <= pin_mux_pkg::PORT_B_RST;
      regs.out_c  <= pin_mux_pkg::PORT_C_RST;
      regs.dir_c  <= pin_mux_pkg::PORT_C_RST;
      regs.mode   <= pin_mux_pkg::MODE_RST;
      aw_held     <= 1'b0;
      aw_addr     <= 8'h00;
      w_held      <= 1'b0;
      w_data      <= 8'h00;
      w_lane0     <= 1'b0;
      awready     <= 1'b0;
      wready      <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= pin_mux_pkg::RESP_OKAY;
      arready     <= 1'b0;
      rvalid      <= 1'b0;
      rdata       <= 32'h0;
      rresp       <= pin_mux_pkg::RESP_OKAY;
      prev_b      <= 8'h00;
      prev_c      <= 6'h00;
      pin_b_out   <= 8'h00;
      pin_b_oe_n  <= 8'hFF;
      pin_c_out   <= 6'h00;
      pin_c_oe_n  <= 6'h3F;
      periph      <= 11'h1D4;
    end else if (ce) begin
      regs        <= next_regs;
      aw_held     <= next_aw_held;
      aw_addr     <= next_aw_addr;
      w_held      <= next_w_held;
      w_data      <= next_w_data;
      w_lane0     <= next_w_lane0;
      awready     <= next_awready;
      wready      <= next_wready;
      bvalid      <= next_bvalid;
      bresp       <= next_bresp;
      arready     <= next_arready;
      rvalid      <= next_rvalid;
      rdata       <= next_rdata;
      rresp       <= next_rresp;
      // Previous pin sample, also the source of the pin read words.
      prev_b      <= pin_b_in;
      prev_c      <= pin_c_in;
      pin_b_out   <= next_b_out;
      pin_b_oe_n  <= next_b_oe_n;
      pin_c_out   <= next_c_out;
      pin_c_oe_n  <= next_c_oe_n;
      periph      <= next_periph;
    end
  end

endmodule // port_b_c_alt_function_mux

//--- tb/board_model.sv
`timescale 1ns/100ps
module board_model (
  input  wire logic                        aclk,
  input  wire logic                        sync_mode,
  input  wire logic                        tx_bit,
  input  wire logic [pin_mux_pkg::B_W-1:0] ext_b,
  input  wire logic [pin_mux_pkg::C_W-1:0] ext_c,
  input  wire logic [pin_mux_pkg::B_W-1:0] pin_b_out,
  input  wire logic [pin_mux_pkg::B_W-1:0] pin_b_oe_n,
  input  wire logic [pin_mux_pkg::C_W-1:0] pin_c_out,
  input  wire logic [pin_mux_pkg::C_W-1:0] pin_c_oe_n,
  output logic [pin_mux_pkg::B_W-1:0]      pin_b_in,
  output logic [pin_mux_pkg::C_W-1:0]      pin_c_in,
  output pin_mux_pkg::serial_tx_t          serial0_tx,
  output pin_mux_pkg::serial_tx_t          serial1_tx,
  output logic                             timer2_overflow_pulse
);
  logic [3:0] tick = 4'h0;
  logic       sclk = 1'b0;
  // The board drives weakly, so a driving device wins every pad.
  assign pin_b_in = (pin_b_oe_n & ext_b) | (~pin_b_oe_n & pin_b_out);
  assign pin_c_in = (pin_c_oe_n & ext_c) | (~pin_c_oe_n & pin_c_out);
  always_ff @(posedge aclk) begin
    tick <= tick + 4'h1;
    sclk <= sync_mode ? ~sclk : 1'b0;
  end
  assign timer2_overflow_pulse = (tick == 4'hF);
  assign serial0_tx = {sclk, tx_bit, sync_mode};
  assign serial1_tx = {sclk, tx_bit, sync_mode};
endmodule // board_model

//--- tb/pin_mux_properties.sv
`timescale 1ns/100ps
module pin_mux_properties (
  input wire logic                        aclk,
  input wire logic                        aresetn,
  input wire logic [pin_mux_pkg::B_W-1:0] pin_b_in,
  input wire logic [pin_mux_pkg::B_W-1:0] pin_b_oe_n,
  input wire logic [pin_mux_pkg::C_W-1:0] pin_c_in,
  input wire logic [pin_mux_pkg::C_W-1:0] pin_c_oe_n,
  input wire logic                        timer2_count_input,
  input wire logic                        timer2_capture_reload_input,
  input wire logic                        serial1_receive_input,
  input wire logic                        ext_irq_four,
  input wire logic                        ext_irq_five_low,
  input wire logic                        ext_irq_six,
  input wire logic                        serial0_receive_input,
  input wire logic                        ext_irq_zero_low,
  input wire logic                        ext_irq_one_low,
  input wire logic                        timer_zero_count_input,
  input wire logic                        timer_one_count_input
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_reset_released: assert property ($rose(aresetn) |->
    &pin_b_oe_n && &pin_c_oe_n) else $error("pad driven after reset");
  a_t2_count: assert property (timer2_count_input |->
    $past(pin_b_in[0])) else $error("timer 2 count without pin");
  a_t2_capture: assert property (timer2_capture_reload_input |->
    $past(pin_b_in[1])) else $error("capture without pin");
  a_rx1_level: assert property (!serial1_receive_input |->
    !$past(pin_b_in[2])) else $error("serial 1 receive wrong");
  a_irq4_rise: assert property (ext_irq_four |->
    $past(pin_b_in[4]) && !$past(pin_b_in[4], 2)) else $error("irq4 bad");
  a_irq5_fall: assert property (!ext_irq_five_low |->
    !$past(pin_b_in[5]) && $past(pin_b_in[5], 2)) else $error("irq5 bad");
  a_irq6_single: assert property (ext_irq_six |=>
    !ext_irq_six) else $error("irq6 pulse too long");
  a_rx0_level: assert property (!serial0_receive_input |->
    !$past(pin_c_in[0])) else $error("serial 0 receive wrong");
  a_irq0_low: assert property (!ext_irq_zero_low |->
    !$past(pin_c_in[2])) else $error("irq0 low without pin low");
  a_irq1_low: assert property (!ext_irq_one_low |->
    !$past(pin_c_in[3])) else $error("irq1 low without pin low");
  a_t0_count: assert property (timer_zero_count_input |->
    $past(pin_c_in[4])) else $error("timer 0 count without pin");
  a_t1_count: assert property (timer_one_count_input |->
    $past(pin_c_in[5])) else $error("timer 1 count without pin");
  cover property (ext_irq_four);
  cover property (!ext_irq_one_low ##1 !ext_irq_one_low);
  cover property ($rose(aresetn));
endmodule // pin_mux_properties

bind port_b_c_alt_function_mux pin_mux_properties props_u (.*);

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, hold_bit;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  logic        bready = 1'b1, rready = 1'b1, sync_mode = 1'b0;
  logic        tx_bit = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ext_b = 8'h00;
  logic [5:0]  ext_c = 6'h00;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        timer2_overflow_pulse, timer2_count_input;
  logic        timer2_capture_reload_input, serial1_receive_input;
  logic        ext_irq_four, ext_irq_five_low, ext_irq_six;
  logic        serial0_receive_input, ext_irq_zero_low, ext_irq_one_low;
  logic        timer_zero_count_input, timer_one_count_input;
  logic [7:0]  pin_b_in, pin_b_out, pin_b_oe_n;
  logic [5:0]  pin_c_in, pin_c_out, pin_c_oe_n;
  pin_mux_pkg::serial_tx_t serial0_tx, serial1_tx;
  int          errors = 0, samples_checked = 0, cnt[5];

  always #12.5 aclk = ~aclk;
  port_b_c_alt_function_mux dut_u (.*);
  board_model model_u (.*);

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    if (n >= 50) begin
      errors++;
      summarize();
    end
    check(32'(bresp), 32'(er));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    if (n >= 50) begin
      errors++;
      summarize();
    end
    check(rdata, exp);
    check(32'(rresp), 32'(er));
  endtask
  task automatic settle();
    repeat (2) @(posedge aclk);
  endtask
  // Counts active cycles of the pulse outputs, so a stretched pulse shows.
  task automatic watch(input int cycles);
    logic [4:0] v;
    foreach (cnt[i]) cnt[i] = 0;
    repeat (cycles) begin
      @(posedge aclk);
      v = {pin_b_out[7], ext_irq_four, ~ext_irq_five_low, ext_irq_six,
           ~ext_irq_zero_low};
      for (int i = 0; i < 5; i++) cnt[i] += int'(v[i]);
    end
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    check(32'({pin_b_oe_n, pin_c_oe_n}), 32'h00003FFF);
    for (int a = 0; a < 9; a++) rd(8'(4 * a), 32'h0, 2'h0);
    rd(8'h40, 32'h0, pin_mux_pkg::RESP_SLVERR);
    wr(pin_mux_pkg::ADDR_PIN_B, 32'h1, pin_mux_pkg::RESP_SLVERR);
    $display("test reset done");
    wr(pin_mux_pkg::ADDR_DIR_B, 32'hFF, 2'h0);
    wr(pin_mux_pkg::ADDR_OUT_B, 32'h5A, 2'h0);
    wr(pin_mux_pkg::ADDR_DIR_C, 32'h3F, 2'h0);
    wr(pin_mux_pkg::ADDR_OUT_C, 32'h2A, 2'h0);
    settle();
    check(32'({pin_b_oe_n, pin_b_out}), 32'h0000005A);
    check(32'({pin_c_oe_n, pin_c_out}), 32'h0000002A);
    rd(pin_mux_pkg::ADDR_PIN_B, 32'h5A, 2'h0);
    $display("test gpio done");
    ext_b <= 8'h23;
    wr(pin_mux_pkg::ADDR_MODE, 32'h1F, 2'h0);
    wr(pin_mux_pkg::ADDR_FSEL_B, 32'hFF, 2'h0);
    settle();
    rd(pin_mux_pkg::ADDR_FSEL_B, 32'hFF, 2'h0);
    check(32'(pin_b_oe_n), 32'h77);
    check(32'({timer2_count_input, timer2_capture_reload_input,
               serial1_receive_input}), 32'h6);
    for (int m = 0; m < 2; m++) begin
      tx_bit <= 1'(m);
      settle();
      check(32'(pin_b_out[3]), 32'(m));
    end
    sync_mode <= 1'b1;
    settle();
    hold_bit = pin_b_out[3];
    @(posedge aclk);
    check(32'(pin_b_out[3]), 32'(!hold_bit));
    sync_mode <= 1'b0;
    ext_b <= 8'h53;
    watch(32);
    check(32'(cnt[3]), 32'h1);
    check(32'(cnt[2]), 32'h1);
    check(32'(cnt[1]), 32'h1);
    check(32'(cnt[4]), 32'h2);
    wr(pin_mux_pkg::ADDR_MODE, 32'h00, 2'h0);
    settle();
    check(32'(timer2_count_input), 32'h0);
    $display("test port b done");
    ext_c <= 6'h3D;
    wr(pin_mux_pkg::ADDR_MODE, 32'h0B, 2'h0);
    wr(pin_mux_pkg::ADDR_FSEL_C, 32'h3F, 2'h0);
    settle();
    check(32'(pin_c_oe_n), 32'h3D);
    check(32'(pin_c_out[1]), 32'h1);
    check(32'({timer_zero_count_input, timer_one_count_input,
               serial0_receive_input}), 32'h7);
    ext_c <= 6'h31;
    watch(8);
    check(32'(cnt[0]), 32'h1);
    check(32'({ext_irq_zero_low, ext_irq_one_low}), 32'h2);
    ext_c <= 6'h3D;
    settle();
    check(32'(ext_irq_one_low), 32'h1);
    // Swap the trigger types: level holds the request, edge gives one pulse.
    wr(pin_mux_pkg::ADDR_MODE, 32'h10, 2'h0);
    settle();
    check(32'({timer_zero_count_input, timer_one_count_input}),
          32'h0);
    ext_c <= 6'h31;
    watch(8);
    check(32'(cnt[0]), 32'h7);
    check(32'({ext_irq_zero_low, ext_irq_one_low}), 32'h1);
    ext_c <= 6'h3D;
    settle();
    check(32'(ext_irq_zero_low), 32'h1);
    $display("test port c done");
    // While the enable is low not even the transmit pin may follow.
    ce <= 1'b0;
    tx_bit <= 1'b0;
    settle();
    check(32'(pin_b_out[3]), 32'h1);
    ce <= 1'b1;
    settle();
    check(32'(pin_b_out[3]), 32'h0);
    $display("test clock enable done");
    wr(pin_mux_pkg::ADDR_FSEL_B, 32'h00, 2'h0);
    settle();
    check(32'({pin_b_oe_n, pin_b_out}), 32'h0000005A);
    check(32'(serial1_receive_input), 32'h1);
    $display("test deselect done");
    summarize();
  end
endmodule // tb_top
